/* File: rtl/itfm_consts.svh */
`ifndef ITFM_CONSTS_SVH
`define ITFM_CONSTS_SVH

`define ITFM_NTERM          7
`define ITFM_REG_REMOTE     4'h7
`define ITFM_REG_CSTOP      4'h8
`define ITFM_REG_OPMODE     4'h9
`define ITFM_REG_UGROUP     4'ha
`define ITFM_REG_STATUS     4'hb
`define ITFM_REG_FUNC_LO    4'hc
`define ITFM_REG_FUNC_HI    4'hd

`define ITFM_RST_SEL0       16'h003c
`define ITFM_RST_SEL1       16'h003d
`define ITFM_RST_SEL2       16'h0000
`define ITFM_RST_SEL3       16'h0001
`define ITFM_RST_SEL4       16'h0002
`define ITFM_RST_SEL5       16'h0018
`define ITFM_RST_SEL6       16'h003e

`define ITFM_C_LOW          16'h0000
`define ITFM_C_MID          16'h0001
`define ITFM_C_HIGH         16'h0002
`define ITFM_C_ALT          16'h0003
`define ITFM_C_CUR          16'h0004
`define ITFM_C_JOG          16'h0005
`define ITFM_C_THERM        16'h0007
`define ITFM_C_REX          16'h0008
`define ITFM_C_RUNEN        16'h000a
`define ITFM_C_ILOCK        16'h000c
`define ITFM_C_PID          16'h000e
`define ITFM_C_BRAKE        16'h000f
`define ITFM_C_X16          16'h0010
`define ITFM_C_VF           16'h0012
`define ITFM_C_SHUT         16'h0018
`define ITFM_C_HOLD         16'h0019
`define ITFM_C_FWD          16'h003c
`define ITFM_C_REV          16'h003d
`define ITFM_C_CLR          16'h003e
`define ITFM_C_X65          16'h0041
`define ITFM_C_X66          16'h0042
`define ITFM_C_X67          16'h0043
`define ITFM_C_NONE         16'h270f

`define ITFM_OPMODE_ILOCK   16'h0007
`define ITFM_CSTOP_ON       16'h0001

`define ITFM_CLK_NS         40
`define ITFM_TICK_NS        100000
`define ITFM_TICK_CYC       (`ITFM_TICK_NS / `ITFM_CLK_NS)
`define ITFM_FAST_RESP_NS   2000000
`define ITFM_SLOW_RESP_NS   20000000
`define ITFM_FAST_FILT      (`ITFM_FAST_RESP_NS / `ITFM_TICK_NS / 4)
`define ITFM_SLOW_FILT      (`ITFM_SLOW_RESP_NS / `ITFM_TICK_NS / 4)

`endif

/* File: rtl/itfm_pkg.sv */
package itfm_pkg;

   typedef enum logic [1:0] {
      ITFM_SRC_NONE  = 2'h0,
      ITFM_SRC_JOG   = 2'h1,
      ITFM_SRC_MULTI = 2'h3,
      ITFM_SRC_PID   = 2'h2
   } itfm_speed_src_type;

   typedef enum logic [1:0] {
      ITFM_MODE_KEEP  = 2'h0,
      ITFM_MODE_EXT   = 2'h1,
      ITFM_MODE_PANEL = 2'h3,
      ITFM_MODE_NET   = 2'h2
   } itfm_mode_sel_type;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } itfm_bus_type;

   typedef struct packed {
      logic fwd_run_command;
      logic rev_run_command;
      logic low_speed_select;
      logic mid_speed_select;
      logic high_speed_select;
      logic alt_setting_select;
      logic current_in_select;
      logic jog_select;
      logic ext_thermal_trip;
      logic fifteen_speed_extend;
      logic run_enable_permit;
      logic panel_interlock;
      logic pid_enable;
      logic brake_open_done;
      logic panel_external_switch;
      logic vf_method_switch;
      logic output_shutoff;
      logic self_hold;
      logic drive_clear_input;
      logic panel_network_switch;
      logic external_network_switch;
      logic command_source_switch;
   } itfm_func_type;

   typedef struct packed {
      logic remote_clear;
      logic remote_decel;
      logic remote_accel;
      logic contact_stop_sel0;
      logic contact_stop_sel1;
   } itfm_alt_type;

   typedef struct packed {
      logic [6:0][15:0]   sel;
      logic [15:0]        remote;
      logic [15:0]        cstop;
      logic [15:0]        opmode;
      logic [15:0]        ugroup;
      logic [15:0]        rdata;
      logic               reject_seen;
      logic               vf_active;
      itfm_func_type      func;
      itfm_alt_type       alt;
      itfm_speed_src_type speed_src;
      itfm_mode_sel_type  mode_sel;
      logic               run_permit;
      logic               panel_ilock;
      logic               output_cut;
      logic               second_set;
      logic               volt_ignore;
      logic               alt_cmd_src;
   } itfm_main_state_type;

   typedef struct packed {
      logic [6:0]      meta;
      logic [6:0]      sync;
      logic [6:0]      last;
      logic [6:0][5:0] cnt;
      logic [6:0]      fast;
      logic [6:0]      slow;
   } itfm_filt_state_type;

   typedef struct packed {
      logic [11:0] cnt;
      logic        tick;
   } itfm_tick_state_type;

endpackage

/* File: rtl/itfm_tick_div.sv */
`timescale 1ns/100ps
`include "itfm_consts.svh"
module itfm_tick_div (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   output logic      o_tick
);
   import itfm_pkg::*;

   itfm_tick_state_type s_ff;
   itfm_tick_state_type nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.tick = 1'b0;
      if (s_ff.cnt == 12'(`ITFM_TICK_CYC - 1)) begin
         nxt_s.cnt  = 12'h000;
         nxt_s.tick = 1'b1;
      end else begin
         nxt_s.cnt = 12'(s_ff.cnt + 12'h001);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_tick = s_ff.tick;
endmodule

/* File: rtl/itfm_term_filter.sv */
`timescale 1ns/100ps
`include "itfm_consts.svh"
module itfm_term_filter (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       i_tick,
   input  wire logic [6:0] i_raw,
   output logic [6:0]      o_fast,
   output logic [6:0]      o_slow
);
   import itfm_pkg::*;

   itfm_filt_state_type s_ff;
   itfm_filt_state_type nxt_s;

   // contacts are synchronised, then must stay stable for a number of ticks
   always_comb begin
      nxt_s = s_ff;
      nxt_s.meta = i_raw;
      nxt_s.sync = s_ff.meta;
      for (int k = 0; k < `ITFM_NTERM; k++) begin
         if (s_ff.sync[k] != s_ff.last[k]) begin
            nxt_s.last[k] = s_ff.sync[k];
            nxt_s.cnt[k]  = 6'h00;
         end else if (i_tick && s_ff.cnt[k] < 6'(`ITFM_SLOW_FILT)) begin
            nxt_s.cnt[k] = 6'(s_ff.cnt[k] + 6'h01);
         end
         if (s_ff.cnt[k] >= 6'(`ITFM_FAST_FILT)) begin
            nxt_s.fast[k] = s_ff.last[k];
         end
         if (s_ff.cnt[k] >= 6'(`ITFM_SLOW_FILT)) begin
            nxt_s.slow[k] = s_ff.last[k];
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_fast = s_ff.fast;
   assign o_slow = s_ff.slow;
endmodule

/* File: rtl/itfm_input_map.sv */
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "itfm_consts.svh"
module itfm_input_map #(
   parameter bit SAFETY_STOP_MODEL = 1'b0
) (
   input  wire logic                   i_mclk,
   input  wire logic                   i_rst_n,
   input  itfm_pkg::itfm_bus_type      i_bus,
   output logic [15:0]                 o_rdata,
   input  wire logic [6:0]             i_term,
   input  wire logic                   i_motor_running,
   input  wire logic                   i_comm_operation,
   output itfm_pkg::itfm_func_type     o_func,
   output itfm_pkg::itfm_alt_type      o_alt,
   output itfm_pkg::itfm_speed_src_type o_speed_src,
   output itfm_pkg::itfm_mode_sel_type o_mode_sel,
   output logic                        o_run_permit,
   output logic                        o_panel_ilock,
   output logic                        o_output_cut,
   output logic                        o_vf_active,
   output logic                        o_second_set,
   output logic                        o_volt_in_ignore,
   output logic                        o_alt_cmd_src,
   output logic                        o_write_reject
);
   import itfm_pkg::*;

   localparam itfm_main_state_type S_RST = '{
      sel:       {`ITFM_RST_SEL6, `ITFM_RST_SEL5, `ITFM_RST_SEL4, `ITFM_RST_SEL3,
                  `ITFM_RST_SEL2, `ITFM_RST_SEL1, `ITFM_RST_SEL0},
      speed_src: ITFM_SRC_NONE,
      mode_sel:  ITFM_MODE_KEEP,
      default:   '0
   };

   itfm_main_state_type s_ff;
   itfm_main_state_type nxt_s;
   logic [6:0]          fast_v;
   logic [6:0]          slow_v;
   logic                tick;
   logic [6:0]          act_m;
   logic [6:0]          fv;
   logic [6:0]          sv;
   logic                remote_on;
   logic                cstop_on;
   logic                low_raw;
   logic                mid_raw;
   logic                high_raw;
   logic                alt_raw;
   logic                sel_wr;
   logic                sel_ok;

   // OR of every terminal whose select holds the given code
   function automatic logic func_or(input logic [6:0][15:0] sel,
                                    input logic [6:0]       v,
                                    input logic [15:0]      code);
      logic r;
      r = 1'b0;
      for (int k = 0; k < `ITFM_NTERM; k++) begin
         if (sel[k] == code) begin
            r = r | v[k];
         end
      end
      return r;
   endfunction

   function automatic logic func_asg(input logic [6:0][15:0] sel,
                                     input logic [15:0]      code);
      return func_or(sel, 7'h7f, code);
   endfunction

   function automatic logic legal_code(input logic [2:0]  idx,
                                       input logic [15:0] code);
      logic r;
      r = 1'b0;
      case (code)
         `ITFM_C_LOW, `ITFM_C_MID, `ITFM_C_HIGH, `ITFM_C_ALT, `ITFM_C_CUR,
         `ITFM_C_JOG, `ITFM_C_THERM, `ITFM_C_REX, `ITFM_C_RUNEN, `ITFM_C_ILOCK,
         `ITFM_C_PID, `ITFM_C_BRAKE, `ITFM_C_X16, `ITFM_C_VF, `ITFM_C_SHUT,
         `ITFM_C_HOLD, `ITFM_C_CLR, `ITFM_C_X65, `ITFM_C_X66, `ITFM_C_X67,
         `ITFM_C_NONE: r = 1'b1;
         `ITFM_C_FWD:  r = (idx == 3'h0);
         `ITFM_C_REV:  r = (idx == 3'h1);
         default:      r = 1'b0;
      endcase
      return r;
   endfunction

   itfm_tick_div u_tick (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .o_tick  (tick)
   );

   // fast copy settles well inside 2ms, slow copy well inside 20ms
   itfm_term_filter u_filt (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_tick  (tick),
      .i_raw   (i_term),
      .o_fast  (fast_v),
      .o_slow  (slow_v)
   );

   always_comb begin
      nxt_s = s_ff;
      act_m = 7'h7f;
      if (SAFETY_STOP_MODEL && !i_comm_operation) begin
         act_m[5] = 1'b0;
      end
      fv = fast_v & act_m;
      sv = slow_v & act_m;
      remote_on = (s_ff.remote != 16'h0000);
      cstop_on  = (s_ff.cstop == `ITFM_CSTOP_ON);

      // one physical signal per speed input, reused by remote and stop modes
      low_raw  = func_or(s_ff.sel, sv, `ITFM_C_LOW);
      mid_raw  = func_or(s_ff.sel, sv, `ITFM_C_MID);
      high_raw = func_or(s_ff.sel, sv, `ITFM_C_HIGH);
      alt_raw  = func_or(s_ff.sel, sv, `ITFM_C_ALT);

      nxt_s.func.low_speed_select   = low_raw & ~remote_on & ~cstop_on;
      nxt_s.func.mid_speed_select   = mid_raw & ~remote_on;
      nxt_s.func.high_speed_select  = high_raw & ~remote_on;
      nxt_s.func.alt_setting_select = alt_raw & ~cstop_on;
      nxt_s.alt.remote_clear        = low_raw & remote_on;
      nxt_s.alt.remote_decel        = mid_raw & remote_on;
      nxt_s.alt.remote_accel        = high_raw & remote_on;
      nxt_s.alt.contact_stop_sel0   = low_raw & cstop_on;
      nxt_s.alt.contact_stop_sel1   = alt_raw & cstop_on;

      nxt_s.func.current_in_select    = func_or(s_ff.sel, sv, `ITFM_C_CUR);
      nxt_s.func.jog_select           = func_or(s_ff.sel, sv, `ITFM_C_JOG);
      nxt_s.func.ext_thermal_trip     = func_or(s_ff.sel, ~slow_v & act_m,
                                                `ITFM_C_THERM);
      nxt_s.func.fifteen_speed_extend = func_or(s_ff.sel, sv, `ITFM_C_REX);
      nxt_s.func.run_enable_permit    = func_or(s_ff.sel, fv, `ITFM_C_RUNEN);
      nxt_s.func.output_shutoff       = func_or(s_ff.sel, fv, `ITFM_C_SHUT);
      nxt_s.func.panel_interlock      = func_or(s_ff.sel, sv, `ITFM_C_ILOCK);
      nxt_s.func.pid_enable           = func_or(s_ff.sel, sv, `ITFM_C_PID);
      nxt_s.func.brake_open_done      = func_or(s_ff.sel, sv, `ITFM_C_BRAKE);
      nxt_s.func.panel_external_switch = func_or(s_ff.sel, sv, `ITFM_C_X16);
      nxt_s.func.vf_method_switch     = func_or(s_ff.sel, sv, `ITFM_C_VF);
      nxt_s.func.self_hold            = func_or(s_ff.sel, sv, `ITFM_C_HOLD);
      nxt_s.func.fwd_run_command      = func_or(s_ff.sel, sv, `ITFM_C_FWD);
      nxt_s.func.rev_run_command      = func_or(s_ff.sel, sv, `ITFM_C_REV);
      nxt_s.func.drive_clear_input    = func_or(s_ff.sel, sv, `ITFM_C_CLR);
      nxt_s.func.panel_network_switch = func_or(s_ff.sel, sv, `ITFM_C_X65);
      nxt_s.func.external_network_switch = func_or(s_ff.sel, sv, `ITFM_C_X66);
      nxt_s.func.command_source_switch = func_or(s_ff.sel, sv, `ITFM_C_X67);

      if (nxt_s.func.jog_select) begin
         nxt_s.speed_src = ITFM_SRC_JOG;
      end else if (nxt_s.func.low_speed_select | nxt_s.func.mid_speed_select |
                   nxt_s.func.high_speed_select | nxt_s.func.fifteen_speed_extend) begin
         nxt_s.speed_src = ITFM_SRC_MULTI;
      end else if (nxt_s.func.pid_enable) begin
         nxt_s.speed_src = ITFM_SRC_PID;
      end else begin
         nxt_s.speed_src = ITFM_SRC_NONE;
      end

      // with no run enable input the shutoff input blocks running instead
      if (func_asg(s_ff.sel, `ITFM_C_RUNEN)) begin
         nxt_s.run_permit = nxt_s.func.run_enable_permit;
      end else begin
         nxt_s.run_permit = ~nxt_s.func.output_shutoff;
      end
      if (func_asg(s_ff.sel, `ITFM_C_ILOCK) || s_ff.opmode != `ITFM_OPMODE_ILOCK) begin
         nxt_s.panel_ilock = nxt_s.func.panel_interlock;
      end else begin
         nxt_s.panel_ilock = nxt_s.func.output_shutoff;
      end
      nxt_s.output_cut = nxt_s.func.output_shutoff;

      if (!i_motor_running) begin
         nxt_s.vf_active = nxt_s.func.vf_method_switch;
      end
      nxt_s.second_set  = nxt_s.func.alt_setting_select |
                          nxt_s.func.vf_method_switch;
      nxt_s.volt_ignore = nxt_s.func.current_in_select;
      nxt_s.alt_cmd_src = nxt_s.func.command_source_switch;

      if (func_asg(s_ff.sel, `ITFM_C_X16)) begin
         nxt_s.mode_sel = nxt_s.func.panel_external_switch ? ITFM_MODE_EXT : ITFM_MODE_PANEL;
      end else if (func_asg(s_ff.sel, `ITFM_C_X65)) begin
         nxt_s.mode_sel = nxt_s.func.panel_network_switch ? ITFM_MODE_PANEL : ITFM_MODE_NET;
      end else if (func_asg(s_ff.sel, `ITFM_C_X66)) begin
         nxt_s.mode_sel = nxt_s.func.external_network_switch ? ITFM_MODE_NET : ITFM_MODE_EXT;
      end else begin
         nxt_s.mode_sel = ITFM_MODE_KEEP;
      end

      nxt_s.rdata = 16'h0000;
      if (i_bus.rd) begin
         case (i_bus.addr)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
               nxt_s.rdata = s_ff.sel[i_bus.addr[2:0]];
            end
            `ITFM_REG_REMOTE: nxt_s.rdata = s_ff.remote;
            `ITFM_REG_CSTOP:  nxt_s.rdata = s_ff.cstop;
            `ITFM_REG_OPMODE: nxt_s.rdata = s_ff.opmode;
            `ITFM_REG_UGROUP: nxt_s.rdata = s_ff.ugroup;
            `ITFM_REG_STATUS: begin
               nxt_s.rdata = {3'h0, s_ff.alt, s_ff.mode_sel, s_ff.speed_src,
                              s_ff.output_cut, s_ff.run_permit, s_ff.reject_seen,
                              s_ff.vf_active};
            end
            `ITFM_REG_FUNC_LO: nxt_s.rdata = s_ff.func[15:0];
            `ITFM_REG_FUNC_HI: nxt_s.rdata = {10'h000, s_ff.func[21:16]};
            default:           nxt_s.rdata = 16'h0000;
         endcase
      end

      sel_wr = i_bus.wr && (i_bus.addr < 4'h7);
      sel_ok = (s_ff.ugroup == 16'h0000) &&
               legal_code(i_bus.addr[2:0], i_bus.wdata);
      if (i_bus.wr) begin
         case (i_bus.addr)
            `ITFM_REG_REMOTE: nxt_s.remote = i_bus.wdata;
            `ITFM_REG_CSTOP:  nxt_s.cstop  = i_bus.wdata;
            `ITFM_REG_OPMODE: nxt_s.opmode = i_bus.wdata;
            `ITFM_REG_UGROUP: nxt_s.ugroup = i_bus.wdata;
            `ITFM_REG_STATUS: begin
               if (i_bus.wdata[1]) begin
                  nxt_s.reject_seen = 1'b0;
               end
            end
            default: begin
               if (sel_wr && sel_ok) begin
                  nxt_s.sel[i_bus.addr[2:0]] = i_bus.wdata;
               end
            end
         endcase
      end
      // a refusal in the clearing cycle still sets the flag
      if (sel_wr && !sel_ok) begin
         nxt_s.reject_seen = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         s_ff <= S_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_rdata          = s_ff.rdata;
   assign o_func           = s_ff.func;
   assign o_alt            = s_ff.alt;
   assign o_speed_src      = s_ff.speed_src;
   assign o_mode_sel       = s_ff.mode_sel;
   assign o_run_permit     = s_ff.run_permit;
   assign o_panel_ilock    = s_ff.panel_ilock;
   assign o_output_cut     = s_ff.output_cut;
   assign o_vf_active      = s_ff.vf_active;
   assign o_second_set     = s_ff.second_set;
   assign o_volt_in_ignore = s_ff.volt_ignore;
   assign o_alt_cmd_src    = s_ff.alt_cmd_src;
   assign o_write_reject   = s_ff.reject_seen;

   logic fwd_else;
   logic rev_else;

   always_comb begin
      fwd_else = 1'b0;
      rev_else = 1'b0;
      for (int k = 0; k < `ITFM_NTERM; k++) begin
         if (k != 0 && s_ff.sel[k] == `ITFM_C_FWD) begin
            fwd_else = 1'b1;
         end
         if (k != 1 && s_ff.sel[k] == `ITFM_C_REV) begin
            rev_else = 1'b1;
         end
      end
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   group_lock_a: assert property (
      sel_wr && s_ff.ugroup != 16'h0000 |=> s_ff.sel == $past(s_ff.sel))
      else $error("select changed while user group nonzero");

   bad_code_a: assert property (
      sel_wr && !legal_code(i_bus.addr[2:0], i_bus.wdata)
      |=> $stable(s_ff.sel) && s_ff.reject_seen)
      else $error("illegal code accepted");

   good_code_a: assert property (
      sel_wr && sel_ok |=> s_ff.sel[$past(i_bus.addr[2:0])] == $past(i_bus.wdata))
      else $error("legal code not stored");

   fwd_only_a: assert property (!fwd_else)
      else $error("forward run code on wrong terminal");

   rev_only_a: assert property (!rev_else)
      else $error("reverse run code on wrong terminal");

   jog_first_a: assert property (
      s_ff.func.jog_select |-> s_ff.speed_src == ITFM_SRC_JOG)
      else $error("jog lost priority");

   vf_hold_a: assert property (
      i_motor_running [*2] |=> $stable(s_ff.vf_active))
      else $error("control method changed while running");

   vf_second_a: assert property (
      s_ff.func.vf_method_switch |-> s_ff.second_set)
      else $error("second setting missing under V/F request");

   shut_cut_a: assert property (
      func_or(s_ff.sel, fv, `ITFM_C_SHUT) |=> s_ff.output_cut)
      else $error("shutoff did not cut output");

   read_data_a: assert property (
      i_bus.rd && i_bus.addr == `ITFM_REG_UGROUP |=> o_rdata == $past(s_ff.ugroup))
      else $error("read data wrong");

   wr_ok_c:   cover property (sel_wr && sel_ok);
   wr_bad_c:  cover property (sel_wr && !sel_ok);
   jog_c:     cover property (s_ff.func.jog_select && s_ff.func.low_speed_select);
   vf_wait_c: cover property (i_motor_running && s_ff.func.vf_method_switch && !s_ff.vf_active);
endmodule

/* File: verification/itfm_contacts.sv */
`timescale 1ns/100ps
module itfm_contacts (
   input  wire logic       i_mclk,
   input  wire logic [6:0] i_close,
   output logic [6:0]      o_term
);
   logic [6:0] term_ff;

   // a contact change reaches the pin one clock after it is commanded
   initial begin
      term_ff = 7'h00;
   end
   always @(posedge i_mclk) begin
      term_ff <= i_close;
   end
   assign o_term = term_ff;
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import itfm_pkg::*;
   logic          i_mclk;
   logic          i_rst_n;
   itfm_bus_type  bus;
   logic [15:0]   rdata;
   logic [6:0]    close_v;
   logic [6:0]    term;
   logic          cut;
   logic          permit;
   logic          ilock;
   logic          running;
   logic          wrej;
   logic [15:0]   v;
   int            fails;
   int            checks;

   itfm_contacts itfm_contacts_inst (.i_mclk(i_mclk), .i_close(close_v), .o_term(term));
   itfm_input_map itfm_input_map_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus(bus),
      .o_rdata(rdata), .i_term(term), .i_motor_running(running), .i_comm_operation(1'b0),
      .o_func(), .o_alt(), .o_speed_src(), .o_mode_sel(), .o_run_permit(permit),
      .o_panel_ilock(ilock), .o_output_cut(cut), .o_vf_active(), .o_second_set(),
      .o_volt_in_ignore(), .o_alt_cmd_src(), .o_write_reject(wrej));

   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task wr(input logic [3:0] a, input logic [15:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_mclk);
      bus <= '0;
      @(posedge i_mclk);
   endtask

   task rd(input logic [3:0] a, output logic [15:0] d);
      bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge i_mclk);
      bus <= '0;
      @(posedge i_mclk);
      d = rdata;
   endtask

   task wait_cut(input logic exp);
      int n;
      n = 0;
      while (cut !== exp && n < 50000) begin
         @(posedge i_mclk);
         n++;
      end
      chk("output_cut", {15'h0000, exp}, {15'h0000, cut});
   endtask

   task t_defaults;
      logic [15:0] defs [7];
      defs = '{16'h003c, 16'h003d, 16'h0000, 16'h0001, 16'h0002, 16'h0018, 16'h003e};
      for (int i = 0; i < 7; i++) begin
         rd(i[3:0], v);
         chk("select default", defs[i], v);
      end
   endtask

   task t_refuse;
      wr(4'h2, 16'h003c);
      rd(4'h2, v);
      chk("low select", 16'h0000, v);
      chk("reject flag", 16'h0001, {15'h0000, wrej});
      wr(4'h0, 16'h003d);
      rd(4'h0, v);
      chk("fwd select", 16'h003c, v);
      wr(4'h3, 16'h0006);
      rd(4'h3, v);
      chk("mid select", 16'h0001, v);
      wr(4'hb, 16'h0002);
      wr(4'ha, 16'h0001);
      wr(4'h3, 16'h0005);
      rd(4'h3, v);
      chk("locked select", 16'h0001, v);
      rd(4'hb, v);
      chk("status reject", 16'h0002, v & 16'h0002);
      wr(4'ha, 16'h0000);
      wr(4'hb, 16'h0002);
      wr(4'h3, 16'h0005);
      rd(4'h3, v);
      chk("mid select", 16'h0005, v);
      rd(4'hb, v);
      chk("status clear", 16'h0000, v & 16'h0002);
   endtask

   task t_shutoff;
      wr(4'h9, 16'h0007);
      close_v <= 7'h20;
      @(posedge i_mclk);
      wait_cut(1'b1);
      chk("run permit", 16'h0000, {15'h0000, permit});
      chk("panel interlock", 16'h0001, {15'h0000, ilock});
      rd(4'hc, v);
      chk("func shutoff", 16'h0020, v & 16'h0020);
      close_v <= 7'h00;
      @(posedge i_mclk);
      wait_cut(1'b0);
      chk("run permit", 16'h0001, {15'h0000, permit});
      chk("panel interlock", 16'h0000, {15'h0000, ilock});
   endtask

   task t_or;
      wr(4'h6, 16'h0018);
      running <= 1'b1;
      close_v <= 7'h40;
      @(posedge i_mclk);
      wait_cut(1'b1);
      close_v <= 7'h00;
      @(posedge i_mclk);
      wait_cut(1'b0);
      running <= 1'b0;
      @(posedge i_mclk);
   endtask

   task print_verdict;
      if (fails == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #(95000 * 40);
      fails++;
      print_verdict;
   end

   initial begin
      i_rst_n = 1'b0;
      bus = '0;
      close_v = 7'h00;
      running = 1'b0;
      fails = 0;
      checks = 0;
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      t_defaults;
      t_refuse;
      t_shutoff;
      t_or;
      print_verdict;
   end
endmodule
